/* rtl/iabr_pkg.sv */
// Constants and types of the I2C address, baud divider and buffer block
package iabr_pkg;
  localparam int DW = 32;
  localparam int AW = 32;
  // Register byte offsets, decoded from haddr[7:0]
  localparam logic [7:0] OFS_ADDR_BAUD = 8'h00;
  localparam logic [7:0] OFS_BUF = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  // Reset values
  localparam logic [7:0] ADDR_BAUD_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'hFF;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // Control field positions
  localparam int CTRL_FSEL_LSB = 0;
  localparam int CTRL_EN_BIT = 4;
  localparam int CTRL_DEDIC_BIT = 5;
  localparam int CTRL_THR_LSB = 6;
  // Status field positions
  localparam int ST_MATCH_BIT = 0;
  localparam int ST_UPDATE_BIT = 1;
  localparam int ST_FULL_BIT = 2;
  localparam int ST_SCL_BIT = 3;
  // Function select codes
  localparam logic [3:0] FSEL_SLV7 = 4'h6;
  localparam logic [3:0] FSEL_SLV10 = 4'h7;
  localparam logic [3:0] FSEL_MASTER = 4'h8;
  localparam logic [3:0] FSEL_SLV7_SP = 4'hE;
  localparam logic [3:0] FSEL_SLV10_SP = 4'hF;
  // Fixed top pattern of the 10-bit high address byte
  localparam logic [4:0] HI_PATTERN = 5'h1E;
  // Bits per byte and the ninth clock for acknowledge
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_ADDR = 4'b0010,
    RX_LOADDR = 4'b0100,
    RX_DATA = 4'b1000
  } iabr_rx_st_t;
endpackage

/* rtl/iabr_match_if.sv */
// Signals between the address sequencer and the address comparator
`timescale 1ns/1ps
interface iabr_match_if;
  logic [7:0] rx_byte;
  logic [7:0] addr;
  logic [7:0] mask;
  logic ten_bit;
  logic high_byte;
  logic hit;
  modport req (output rx_byte, output addr, output mask, output ten_bit, output high_byte, input hit);
  modport cmp (input rx_byte, input addr, input mask, input ten_bit, input high_byte, output hit);
endinterface

/* rtl/iabr_addr_match.sv */
// Masked own-address comparator for 7-bit and 10-bit slave addressing
`timescale 1ns/1ps
module iabr_addr_match (
  iabr_match_if.cmp mif
);
  import iabr_pkg::*;
  logic [7:0] diff;
  logic [7:0] care;
  always_comb begin
    diff = mif.rx_byte ^ mif.addr;
    care = mif.mask;
    if (!mif.ten_bit) begin
      care[0] = 1'b0;
    end
    if (mif.ten_bit && mif.high_byte) begin
      mif.hit = (mif.rx_byte[7:3] == HI_PATTERN) && ((diff[2:1] & care[2:1]) == 2'h0);
    end else begin
      mif.hit = ((diff & care) == 8'h00);
    end
  end
endmodule

/* rtl/iabr_top.sv */
// I2C address/baud divider register, buffer, mask, SCL generator and slave address matcher
// How it works
// - master SCL period is 4 times (divider+1)
// - 10-bit high byte top must be 11110
// - 10-bit high byte compares register bits 2:1
// - 10-bit low byte compares all eight bits
// - 7-bit address from bits 7:1, bit0 ignored
// - dedicated pins override input threshold select
// - only mask-one address bits are compared
// - mask bit 0 used only in 10-bit
`timescale 1ns/1ps
module iabr_top (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [iabr_pkg::AW-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [iabr_pkg::DW-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [iabr_pkg::DW-1:0] hrdata,
  input wire logic scl_pad,
  output logic scl_val,
  output logic scl_en,
  input wire logic sda_pad,
  output logic sda_val,
  output logic sda_en,
  output logic [1:0] pad_threshold,
  output logic pad_i2c_levels
);
  import iabr_pkg::*;

  logic [7:0] add_r, buf_r, mask_r, ctrl_r, ofs_r, rx_sh_r, rx_now, rd_mux, div_cnt_r;
  logic match_r, update_r, full_r, wr_pend_r, rd_pend_r, aphase, wr_add, wr_buf, wr_mask, wr_ctrl, wr_stat;
  logic rd_buf, ten_bit, slave_mode, run, tick, start_det, stop_det, scl_rise, byte_done, first_hit, low_hit;
  logic scl_s1_r, scl_s2_r, scl_q_r, sda_s1_r, sda_s2_r, sda_q_r;
  logic [DW-1:0] hrdata_r;
  logic [3:0] fsel, bit_cnt_r;
  logic [1:0] phase_r;
  iabr_rx_st_t rx_st_r;

  iabr_match_if mif ();
  iabr_addr_match u_match (
    .mif(mif)
  );

  // Register bus slave
  assign aphase = hsel & htrans[1] & hready;
  assign hresp = 1'b0;
  // One wait state on reads so a read straight after a write sees the new value
  assign hreadyout = ~rd_pend_r;
  assign hrdata = hrdata_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      ofs_r <= 8'h00;
    end else begin
      wr_pend_r <= aphase & hwrite;
      rd_pend_r <= aphase & ~hwrite;
      if (aphase) begin
        ofs_r <= haddr[7:0];
      end
    end
  end

  always_comb begin
    wr_add = 1'b0;
    wr_buf = 1'b0;
    wr_mask = 1'b0;
    wr_ctrl = 1'b0;
    wr_stat = 1'b0;
    if (wr_pend_r && ofs_r == OFS_ADDR_BAUD) begin
      wr_add = 1'b1;
    end else if (wr_pend_r && ofs_r == OFS_BUF) begin
      wr_buf = 1'b1;
    end else if (wr_pend_r && ofs_r == OFS_MASK) begin
      wr_mask = 1'b1;
    end else if (wr_pend_r && ofs_r == OFS_CTRL) begin
      wr_ctrl = 1'b1;
    end else if (wr_pend_r && ofs_r == OFS_STATUS) begin
      wr_stat = 1'b1;
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    if (ofs_r == OFS_ADDR_BAUD) begin
      rd_mux = add_r;
    end else if (ofs_r == OFS_BUF) begin
      rd_mux = buf_r;
    end else if (ofs_r == OFS_MASK) begin
      rd_mux = mask_r;
    end else if (ofs_r == OFS_CTRL) begin
      rd_mux = ctrl_r;
    end else if (ofs_r == OFS_STATUS) begin
      rd_mux = {4'h0, scl_s2_r, full_r, update_r, match_r};
    end
  end
  assign rd_buf = rd_pend_r && (ofs_r == OFS_BUF);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata_r <= 32'h0000_0000;
    end else if (rd_pend_r) begin
      hrdata_r <= {24'h00_0000, rd_mux};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      add_r <= ADDR_BAUD_RST;
      mask_r <= MASK_RST;
      ctrl_r <= CTRL_RST;
    end else begin
      if (wr_add) begin
        add_r <= hwdata[7:0];
      end
      if (wr_mask) begin
        mask_r <= hwdata[7:0];
      end
      if (wr_ctrl) begin
        ctrl_r <= hwdata[7:0];
      end
    end
  end

  // shared transfer buffer
  // A completed byte wins over a software write in the same cycle; no reset, contents start unknown
  always_ff @(posedge clk) begin
    if (byte_done) begin
      buf_r <= rx_now;
    end else if (wr_buf) begin
      buf_r <= hwdata[7:0];
    end
  end

  // Status flags: hardware set wins over write-one-to-clear and over the clearing read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      match_r <= 1'b0;
      update_r <= 1'b0;
      full_r <= 1'b0;
    end else begin
      if (first_hit && !ten_bit || low_hit) begin
        match_r <= 1'b1;
      end else if (wr_stat && hwdata[ST_MATCH_BIT]) begin
        match_r <= 1'b0;
      end
      if (first_hit && ten_bit) begin
        update_r <= 1'b1;
      end else if (wr_stat && hwdata[ST_UPDATE_BIT]) begin
        update_r <= 1'b0;
      end
      if (byte_done) begin
        full_r <= 1'b1;
      end else if (rd_buf) begin
        full_r <= 1'b0;
      end
    end
  end

  assign fsel = ctrl_r[CTRL_FSEL_LSB +: 4];
  assign ten_bit = (fsel == FSEL_SLV10) || (fsel == FSEL_SLV10_SP);
  assign slave_mode = ctrl_r[CTRL_EN_BIT] && (ten_bit || fsel == FSEL_SLV7 || fsel == FSEL_SLV7_SP);
  assign run = ctrl_r[CTRL_EN_BIT] && (fsel == FSEL_MASTER);

  assign pad_i2c_levels = ctrl_r[CTRL_EN_BIT] && ctrl_r[CTRL_DEDIC_BIT];
  assign pad_threshold = pad_i2c_levels ? 2'h0 : ctrl_r[CTRL_THR_LSB +: 2];

  // relies on divider above 2; smaller values still run but are outside the supported range
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt_r <= 8'h00;
    end else if (!run || tick) begin
      div_cnt_r <= 8'h00;
    end else begin
      div_cnt_r <= div_cnt_r + 8'h01;
    end
  end
  // A divider lowered mid-count ends the quarter at once instead of wrapping through 255
  assign tick = run && (div_cnt_r >= add_r);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_r <= 2'h0;
    end else if (!run) begin
      phase_r <= 2'h0;
    end else if (tick) begin
      phase_r <= phase_r + 2'h1;
    end
  end
  assign scl_en = run && !phase_r[1];
  assign scl_val = 1'b0;
  // Slave transmit and acknowledge drive are outside this block
  assign sda_val = 1'b0;
  assign sda_en = 1'b0;

  // Pin synchronisers; edge detection compares the second stage with the third stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_q_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_s1_r <= scl_pad;
      scl_s2_r <= scl_s1_r;
      scl_q_r <= scl_s2_r;
      sda_s1_r <= sda_pad;
      sda_s2_r <= sda_s1_r;
      sda_q_r <= sda_s2_r;
    end
  end
  assign start_det = scl_s2_r && scl_q_r && sda_q_r && !sda_s2_r;
  assign stop_det = scl_s2_r && scl_q_r && !sda_q_r && sda_s2_r;
  assign scl_rise = scl_s2_r && !scl_q_r;
  assign rx_now = {rx_sh_r[6:0], sda_s2_r};
  assign byte_done = scl_rise && (bit_cnt_r == LAST_BIT) && (rx_st_r != RX_IDLE);

  assign mif.rx_byte = rx_now;
  assign mif.addr = add_r;
  assign mif.mask = mask_r;
  assign mif.ten_bit = ten_bit;
  assign mif.high_byte = (rx_st_r == RX_ADDR);
  assign first_hit = byte_done && (rx_st_r == RX_ADDR) && mif.hit;
  assign low_hit = byte_done && (rx_st_r == RX_LOADDR) && mif.hit;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt_r <= 4'h0;
      rx_sh_r <= 8'h00;
    end else if (start_det || !slave_mode) begin
      bit_cnt_r <= 4'h0;
    end else if (scl_rise && rx_st_r != RX_IDLE) begin
      if (bit_cnt_r == ACK_BIT) begin
        bit_cnt_r <= 4'h0;
      end else begin
        bit_cnt_r <= bit_cnt_r + 4'h1;
        rx_sh_r <= rx_now;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_st_r <= RX_IDLE;
    end else if (!slave_mode || stop_det) begin
      rx_st_r <= RX_IDLE;
    end else if (start_det) begin
      rx_st_r <= RX_ADDR;
    end else if (byte_done) begin
      case (rx_st_r)
        RX_ADDR: begin
          if (!mif.hit) begin
            rx_st_r <= RX_IDLE;
          end else if (ten_bit) begin
            rx_st_r <= RX_LOADDR;
          end else begin
            rx_st_r <= RX_DATA;
          end
        end
        RX_LOADDR: begin
          rx_st_r <= mif.hit ? RX_DATA : RX_IDLE;
        end
        default: begin
          rx_st_r <= rx_st_r;
        end
      endcase
    end
  end

  // Helper: cycles between SCL low-drive starts while the divider is unchanged
  logic [10:0] per_cnt_r;
  logic per_ok_r, scl_en_q_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      per_cnt_r <= 11'h000;
      per_ok_r <= 1'b0;
      scl_en_q_r <= 1'b0;
    end else begin
      scl_en_q_r <= scl_en;
      per_cnt_r <= (scl_en && !scl_en_q_r) ? 11'h001 : per_cnt_r + 11'h001;
      if (!run || wr_add) begin
        per_ok_r <= 1'b0;
      end else if (scl_en && !scl_en_q_r) begin
        per_ok_r <= 1'b1;
      end
    end
  end

  AST_BAUD_PERIOD: assert property (@(posedge clk) disable iff (!arst_n)
    ($rose(scl_en) && per_ok_r) |-> (per_cnt_r == {1'b0, add_r, 2'b00} + 11'h004))
    else $error("SCL period differs from four times divider plus one");
  AST_HI_FIXED: assert property (@(posedge clk) disable iff (!arst_n)
    (ten_bit && mif.high_byte && rx_now[7:3] != HI_PATTERN) |-> !mif.hit)
    else $error("10-bit high byte matched without fixed pattern");
  AST_HI_BITS: assert property (@(posedge clk) disable iff (!arst_n)
    (ten_bit && mif.high_byte && rx_now[7:3] == HI_PATTERN && mask_r[2:1] == 2'h3)
    |-> (mif.hit == (rx_now[2:1] == add_r[2:1])))
    else $error("10-bit high byte compare wrong");
  AST_LO_BYTE: assert property (@(posedge clk) disable iff (!arst_n)
    (ten_bit && rx_st_r == RX_LOADDR && mask_r == 8'hFF) |-> (mif.hit == (rx_now == add_r)))
    else $error("10-bit low byte compare wrong");
  AST_SEVEN: assert property (@(posedge clk) disable iff (!arst_n)
    (!ten_bit && mask_r == 8'hFF) |-> (mif.hit == (rx_now[7:1] == add_r[7:1])))
    else $error("7-bit address compare wrong");
  AST_THRESH: assert property (@(posedge clk) disable iff (!arst_n)
    (ctrl_r[CTRL_EN_BIT] && ctrl_r[CTRL_DEDIC_BIT]) |-> (pad_threshold == 2'h0 && pad_i2c_levels))
    else $error("Threshold select not overridden on dedicated pins");
  AST_MASK_ZERO: assert property (@(posedge clk) disable iff (!arst_n)
    (!ten_bit && mask_r[7:1] == 7'h00) |-> mif.hit)
    else $error("Masked-out bits still compared");
  AST_MASK0: assert property (@(posedge clk) disable iff (!arst_n)
    (!ten_bit && mask_r == 8'hFF && rx_now[7:1] == add_r[7:1] && rx_now[0] != add_r[0]) |-> mif.hit)
    else $error("Mask bit 0 applied in 7-bit mode");
  AST_MATCH_SET: assert property (@(posedge clk) disable iff (!arst_n)
    (first_hit && !ten_bit) |=> (match_r && rx_st_r != RX_IDLE))
    else $error("Address match not flagged");
  AST_BUF_LOAD: assert property (@(posedge clk) disable iff (!arst_n)
    byte_done |=> (buf_r == $past(rx_now) && full_r))
    else $error("Received byte not in buffer");
  CV_SCL_RUN: cover property (@(posedge clk) disable iff (!arst_n) $rose(scl_en) && per_ok_r);
  CV_MATCH7: cover property (@(posedge clk) disable iff (!arst_n) first_hit && !ten_bit);
  CV_MATCH10: cover property (@(posedge clk) disable iff (!arst_n) low_hit);
  CV_READ: cover property (@(posedge clk) disable iff (!arst_n) rd_buf && full_r);
endmodule

/* tb/iabr_i2c_master_model.sv */
// Behavioural I2C bus master driving the open-drain SCL and SDA lines
`timescale 1ns/1ps
module iabr_i2c_master_model (
  input wire logic clk,
  output logic scl_low,
  output logic sda_low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // Six clocks a level, above the three stages of the receiver's synchroniser
  task automatic hold();
    repeat (6) @(posedge clk);
  endtask
  task automatic pulse();
    scl_low <= 1'b0;
    hold();
    scl_low <= 1'b1;
    hold();
  endtask
  // Start: SDA falls while SCL is high
  task automatic start();
    scl_low <= 1'b0;
    sda_low <= 1'b0;
    hold();
    sda_low <= 1'b1;
    hold();
    scl_low <= 1'b1;
    hold();
  endtask
  // Data changes only while SCL is low, MSB first
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sda_low <= ~b[i];
      hold();
      pulse();
    end
    // Ack slot: SDA released to the pull-up, nobody acknowledges here
    sda_low <= 1'b0;
    hold();
    pulse();
  endtask
  // Stop: SDA rises while SCL is high
  task automatic stop();
    sda_low <= 1'b1;
    hold();
    scl_low <= 1'b0;
    hold();
    sda_low <= 1'b0;
    hold();
  endtask
endmodule

/* tb/iabr_i2c_address_baud_register_tb.sv */
// Self-checking bench of the I2C address, baud divider and buffer block
`timescale 1ns/1ps
module iabr_i2c_address_baud_register_tb;
  import iabr_pkg::*;
  logic clk;
  logic arst_n;
  logic hsel;
  logic [AW-1:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [DW-1:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [DW-1:0] hrdata;
  logic scl_val;
  logic scl_en;
  logic sda_val;
  logic sda_en;
  logic [1:0] pad_threshold;
  logic pad_i2c_levels;
  logic m_scl_low;
  logic m_sda_low;
  logic [DW-1:0] rd;
  int errors;
  int cmp_count;
  int n;
  // Open-drain lines with pull-ups
  wire scl_line = !(m_scl_low || (scl_en && !scl_val));
  wire sda_line = !(m_sda_low || (sda_en && !sda_val));

  always #2 clk = ~clk;

  iabr_top DUT (
    .clk(clk),
    .arst_n(arst_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(3'b010),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .scl_pad(scl_line),
    .scl_val(scl_val),
    .scl_en(scl_en),
    .sda_pad(sda_line),
    .sda_val(sda_val),
    .sda_en(sda_en),
    .pad_threshold(pad_threshold),
    .pad_i2c_levels(pad_i2c_levels)
  );

  iabr_i2c_master_model u_mst (
    .clk(clk),
    .scl_low(m_scl_low),
    .sda_low(m_sda_low)
  );

  task automatic report_and_stop();
    $display("TB: errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic to_fail();
    errors++;
    $display("CHECK FAILED wait expected done seen timeout");
    report_and_stop();
  endtask

  // Ready is looked at before the edge so the sample never races the edge's updates
  task automatic wait_ready();
    int k;
    logic r;
    k = 0;
    r = 1'b0;
    while (!r) begin
      @(negedge clk);
      r = (hreadyout === 1'b1);
      rd = hrdata;
      @(posedge clk);
      k++;
      if (k > 64) to_fail();
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, wd};
    wait_ready();
    chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
  endtask

  task automatic rd_chk(input string w, input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(w, {24'h00_0000, e}, rd);
  endtask

  task automatic t_regs();
    rd_chk("divider reset", OFS_ADDR_BAUD, ADDR_BAUD_RST);
    rd_chk("mask reset", OFS_MASK, MASK_RST);
    rd_chk("ctrl reset", OFS_CTRL, CTRL_RST);
    bus(1'b1, OFS_BUF, 8'h5A);
    rd_chk("buffer", OFS_BUF, 8'h5A);
    bus(1'b1, OFS_BUF, 8'hA5);
    rd_chk("buffer", OFS_BUF, 8'hA5);
    bus(1'b1, OFS_ADDR_BAUD, 8'hC3);
    rd_chk("divider", OFS_ADDR_BAUD, 8'hC3);
    bus(1'b1, 8'h14, 8'hFF);
    rd_chk("unmapped", 8'h14, 8'h00);
    $display("TB: test regs done");
  endtask

  task automatic level_len(input logic lvl);
    n = 0;
    while (scl_en === lvl) begin
      n++;
      @(negedge clk);
      if (n > 2000) to_fail();
    end
  endtask

  // Divider values 0 to 2 are never used in this mode
  task automatic t_scl(input logic [7:0] div);
    bus(1'b1, OFS_ADDR_BAUD, div);
    bus(1'b1, OFS_CTRL, {3'b000, 1'b1, FSEL_MASTER});
    @(negedge clk);
    level_len(1'b0);
    level_len(1'b1);
    level_len(1'b0);
    chk("scl low cycles", 32'(2 * (int'(div) + 1)), 32'(n));
    level_len(1'b1);
    chk("scl high cycles", 32'(2 * (int'(div) + 1)), 32'(n));
    @(posedge clk);
    bus(1'b1, OFS_CTRL, 8'h00);
    @(negedge clk);
    chk("scl stopped", 32'h0000_0000, {31'h0000_0000, scl_en});
    chk("scl drive value", 32'h0000_0000, {31'h0000_0000, scl_val});
    @(posedge clk);
    $display("TB: test scl done");
  endtask

  task automatic pads(input logic [1:0] thr, input logic lv);
    @(negedge clk);
    chk("threshold", {30'h0000_0000, thr}, {30'h0000_0000, pad_threshold});
    chk("i2c levels", {31'h0000_0000, lv}, {31'h0000_0000, pad_i2c_levels});
    chk("sda released", 32'h0000_0000, {30'h0000_0000, sda_en, sda_val});
    @(posedge clk);
  endtask

  task automatic t_pads();
    bus(1'b1, OFS_CTRL, {2'b11, 1'b0, 1'b1, FSEL_SLV7});
    pads(2'b11, 1'b0);
    bus(1'b1, OFS_CTRL, {2'b11, 1'b1, 1'b1, FSEL_SLV7});
    pads(2'b00, 1'b1);
    $display("TB: test pads done");
  endtask

  // One framed transfer, then the update and match flags are read and cleared
  task automatic frame(input logic [7:0] b0, input logic [7:0] b1, input logic two, input logic [1:0] st);
    u_mst.start();
    u_mst.send_byte(b0);
    if (two) u_mst.send_byte(b1);
    u_mst.stop();
    repeat (8) @(posedge clk);
    bus(1'b0, OFS_STATUS, 8'h00);
    // SCL idles high and the address byte always fills the buffer
    chk("status flags", {28'h000_0000, 2'b11, st}, {28'h000_0000, rd[3:0]});
    bus(1'b1, OFS_STATUS, 8'h03);
  endtask

  task automatic t_slv7();
    bus(1'b1, OFS_ADDR_BAUD, 8'hA5);
    bus(1'b1, OFS_CTRL, {3'b000, 1'b1, FSEL_SLV7});
    frame(8'hA4, 8'h3C, 1'b1, 2'b01);
    rd_chk("received byte", OFS_BUF, 8'h3C);
    rd_chk("full cleared", OFS_STATUS, 8'h08);
    frame(8'hA6, 8'h00, 1'b0, 2'b00);
    bus(1'b1, OFS_MASK, 8'hFD);
    frame(8'hA6, 8'h00, 1'b0, 2'b01);
    bus(1'b1, OFS_MASK, 8'hFF);
    bus(1'b1, OFS_ADDR_BAUD, 8'h30);
    bus(1'b1, OFS_CTRL, {3'b000, 1'b1, FSEL_SLV7_SP});
    frame(8'h31, 8'h00, 1'b0, 2'b01);
    frame(8'hB0, 8'h00, 1'b0, 2'b00);
    $display("TB: test slave7 done");
  endtask

  task automatic t_slv10();
    bus(1'b1, OFS_ADDR_BAUD, 8'h5B);
    bus(1'b1, OFS_CTRL, {3'b000, 1'b1, FSEL_SLV10});
    frame(8'hF2, 8'h5B, 1'b1, 2'b11);
    rd_chk("received byte", OFS_BUF, 8'h5B);
    frame(8'hF4, 8'h5B, 1'b1, 2'b00);
    frame(8'h72, 8'h5B, 1'b1, 2'b00);
    frame(8'hF2, 8'h5A, 1'b1, 2'b10);
    bus(1'b1, OFS_MASK, 8'hFE);
    bus(1'b1, OFS_CTRL, {3'b000, 1'b1, FSEL_SLV10_SP});
    frame(8'hF2, 8'h5A, 1'b1, 2'b11);
    $display("TB: test slave10 done");
  endtask

  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = '0;
    errors = 0;
    cmp_count = 0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_scl(8'h03);
    t_scl(8'hFF);
    t_pads();
    t_slv7();
    t_slv10();
    report_and_stop();
  end
endmodule
